// [pdio_regs.vh]
// Purpose: constants for the discrete I/O front end
// Assumes: 50 MHz clock (20 ns period)
// Notes:   times in microseconds, counts derived from them
`ifndef PDIO_REGS_VH
`define PDIO_REGS_VH
`define PDIO_CLK_MHZ          50
`define PDIO_RELEASE_US       18000
`define PDIO_RELEASE_CYC      (`PDIO_RELEASE_US * `PDIO_CLK_MHZ)
`define PDIO_WDOG_US          2300000
`define PDIO_WDOG_CYC         (`PDIO_WDOG_US * `PDIO_CLK_MHZ)
`define PDIO_OUT_LO           8
`define PDIO_OUT_HI           15
`define PDIO_DIN_A_LINE       6
`define PDIO_DIN_B_LINE       7
`define PDIO_ST_RELEASE       2'h0
`define PDIO_ST_RUN           2'h1
`endif

// [pdio_core.v]
// Purpose: discrete I/O front end of a small controller board, device side
// Assumes: single clk, asynchronous active-high rst; field pins pass a 3-stage sync
// Notes:   ctrl_* ports are the controller's line drivers; field_* are terminals
`default_nettype none
`include "pdio_regs.vh"

// Operation
// (RULE_01) The eight output channels follow controller lines 8 to 15 through protected drivers.
// (RULE_02) The controller energises a channel by driving its line low as an output.
// (RULE_03) After any fault restart all output lines are released for 18 ms.
// (RULE_04) The watchdog counts down and reloads on every completed instruction.
// (RULE_05) On watchdog expiry the controller resets and restarts its program.
// (RULE_06) A runaway program gives 18 ms off then about 2.3 s on, repeating.
// (RULE_07) Each driver cuts out on overload or heat and recovers silently.
// (RULE_08) Inputs 1 to 8 reach the controller through a shift register on three lines.
// (RULE_09) Each input sits in its own bit of the 8-bit input image byte.
// (RULE_10) The controller loads high, clocks eight bits msb first sampling before each edge.
// (RULE_11) Inputs 9 and 10 go straight to controller lines 6 and 7.
// (RULE_12) Each input reads high with no voltage and low with signal applied.
// (RULE_13) The controller picks an analog range by writing a configuration byte; pdio_core has no analog range or configuration byte input.
// (RULE_14) At power-up all output lines stay released until the program drives them.
module pdio_core #(
    parameter RELEASE_CYC = `PDIO_RELEASE_CYC,
    parameter WDOG_CYC    = `PDIO_WDOG_CYC
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] ctrl_out_level,
    input  wire [7:0] ctrl_out_enable,
    input  wire       instr_done,
    input  wire [7:0] driver_fault,
    input  wire [7:0] field_voltage,
    input  wire [1:0] field_direct_voltage,
    input  wire       sr_clk,
    input  wire       sr_load,
    output reg        sr_data,
    output reg        direct_input_a_level,
    output reg        direct_input_b_level,
    output reg  [7:0] channel_on,
    output reg        program_restart,
    output reg        lines_released,
    output reg  [7:0] input_image_byte
);

    // ==========================================================
    // input synchronisers, three stages, change when 2nd and 3rd agree
    reg [9:0] s1_q, s2_q, s3_q, in_q;
    reg [2:0] c1_q, c2_q, c3_q, cin_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q  <= 10'h000;
            s2_q  <= 10'h000;
            s3_q  <= 10'h000;
            in_q  <= 10'h000;
            c1_q  <= 3'h0;
            c2_q  <= 3'h0;
            c3_q  <= 3'h0;
            cin_q <= 3'h0;
        end else begin
            s1_q <= {field_direct_voltage, field_voltage};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // hold while the last two stages disagree, take their value once they match
            in_q <= (in_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
            c1_q <= {instr_done, sr_load, sr_clk};
            c2_q <= c1_q;
            c3_q <= c2_q;
            cin_q <= (cin_q & (c2_q ^ c3_q)) | (c2_q & ~(c2_q ^ c3_q));
        end
    end

    // ==========================================================
    // input image: voltage present reads 0
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            input_image_byte     <= 8'hff;
            direct_input_a_level <= 1'b1;
            direct_input_b_level <= 1'b1;
        end else begin
            input_image_byte     <= ~in_q[7:0];     // [RULE_12] [RULE_09]
            direct_input_a_level <= ~in_q[8];       // [RULE_11] [RULE_12]
            direct_input_b_level <= ~in_q[9];       // [RULE_11]
        end
    end

    // ==========================================================
    // shift register: load low captures, load high holds and each clock rise shifts
    reg [7:0] sh_q;
    reg       sck_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_q    <= 8'hff;
            sck_q   <= 1'b0;
            sr_data <= 1'b1;
        end else begin
            sck_q <= cin_q[0];
            if (!cin_q[1])
                sh_q <= ~in_q[7:0];                 // [RULE_08]
            else if (cin_q[0] && !sck_q)
                sh_q <= {sh_q[6:0], 1'b1};          // [RULE_08] [RULE_10]
            sr_data <= sh_q[7];                     // msb first [RULE_10]
        end
    end

    // ==========================================================
    // watchdog and restart release
    reg [31:0] wd_q;
    reg [31:0] rel_q;
    reg [1:0]  st_q;
    reg        done_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_q            <= 32'h0;
            rel_q           <= 32'h0;
            st_q            <= `PDIO_ST_RELEASE;    // [RULE_14]
            done_q          <= 1'b0;
            program_restart <= 1'b0;
        end else begin
            done_q          <= cin_q[2];
            program_restart <= 1'b0;
            case (st_q)
                `PDIO_ST_RELEASE: begin
                    if (rel_q >= RELEASE_CYC - 1) begin    // [RULE_03]
                        st_q  <= `PDIO_ST_RUN;
                        rel_q <= 32'h0;
                        wd_q  <= WDOG_CYC - 1;
                    end else
                        rel_q <= rel_q + 32'h1;
                end
                `PDIO_ST_RUN: begin
                    if (cin_q[2] && !done_q)
                        wd_q <= WDOG_CYC - 1;              // [RULE_04]
                    else if (wd_q == 32'h0) begin
                        st_q            <= `PDIO_ST_RELEASE; // [RULE_05] [RULE_06]
                        program_restart <= 1'b1;
                    end else
                        wd_q <= wd_q - 32'h1;              // [RULE_04]
                end
                default: st_q <= `PDIO_ST_RELEASE;
            endcase
        end
    end

    // ==========================================================
    // output drivers: on when line enabled and low, off during release or fault
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_on     <= 8'h00;
            lines_released <= 1'b1;
        end else begin
            lines_released <= (st_q != `PDIO_ST_RUN);
            if (st_q != `PDIO_ST_RUN)
                channel_on <= 8'h00;                               // [RULE_03] [RULE_14]
            else
                channel_on <= ctrl_out_enable & ~ctrl_out_level    // [RULE_01] [RULE_02]
                              & ~driver_fault;                     // silent [RULE_07]
        end
    end

endmodule
`default_nettype wire

// [pdio_prog_model.sv]
// Purpose: program stand-in that keeps completing instructions
// Assumes: feed high while the program runs
// Notes:   a rising edge every 16 cycles, well inside the watchdog
// converter range byte is not driven here, outside this block
`default_nettype none
module pdio_prog_model (
    input  wire logic clk,
    input  wire logic feed,
    output var  logic instr_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q = 3'h0;
    initial instr_done = 1'b0;
    always @(posedge clk) begin
        cnt_q <= cnt_q + 3'h1;
        if (feed && cnt_q == 3'h7) instr_done <= !instr_done;
    end
endmodule
`default_nettype wire

// [pdio_core_checker.sv]
// Purpose: port-level assertions for pdio_core
// Assumes: single clock, reset disables every check
// Notes:   input sync takes about five cycles, so windows run to eight
`default_nettype none
module pdio_core_checker (
    input wire logic       clk, rst, instr_done, sr_clk, sr_load, sr_data,
    input wire logic       direct_input_a_level, direct_input_b_level,
    input wire logic       program_restart, lines_released,
    input wire logic [7:0] ctrl_out_level, ctrl_out_enable, driver_fault, field_voltage,
    input wire logic [7:0] channel_on, input_image_byte,
    input wire logic [1:0] field_direct_voltage
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_released_off: assert property (lines_released |-> channel_on == 8'h00)
        else $error("channel on while lines released");
    a_restart_pulse: assert property (program_restart |=> !program_restart ##1 lines_released)
        else $error("restart not a single pulse into release");
    a_release_len: assert property ($fell(lines_released) |-> $past(lines_released, 8))
        else $error("release period too short");
    a_fault_cuts: assert property (driver_fault[0] && $past(driver_fault[0]) |-> !channel_on[0])
        else $error("faulted driver still on");
    a_out_follow: assert property (($stable(ctrl_out_level) && $stable(ctrl_out_enable)
        && driver_fault == 8'h00 && !lines_released)[*4] |-> channel_on == (ctrl_out_enable & ~ctrl_out_level))
        else $error("channels do not follow lines");
    a_image_inv: assert property ($stable(field_voltage)[*8] |-> input_image_byte == ~field_voltage)
        else $error("input image wrong");
    a_direct_a: assert property ($stable(field_direct_voltage)[*8] |-> direct_input_a_level == !field_direct_voltage[0])
        else $error("direct input a wrong");
    a_direct_b: assert property ($stable(field_direct_voltage)[*8] |-> direct_input_b_level == !field_direct_voltage[1])
        else $error("direct input b wrong");
endmodule
bind pdio_core pdio_core_checker i_chk (.*);
`default_nettype wire

// [pdio_core_bench.sv]
// Purpose: directed bench for pdio_core with a program stand-in
// Assumes: RELEASE_CYC 20 and WDOG_CYC 100 keep the run short
// Notes:   outputs are sampled at the falling edge, once settled
`default_nettype none
module pdio_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, feed = 1'b1, instr_done, sr_clk = 1'b0, sr_load = 1'b0;
    logic sr_data, dia, dib, program_restart, lines_released;
    logic [7:0] lvl = 8'hff, ena = 8'h00, flt = 8'h00, fv = 8'h00, chon, img;
    logic [1:0] fdv = 2'h0;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    pdio_core #(.RELEASE_CYC(20), .WDOG_CYC(100)) i_dut (.clk(clk), .rst(rst),
        .ctrl_out_level(lvl), .ctrl_out_enable(ena), .instr_done(instr_done),
        .driver_fault(flt), .field_voltage(fv), .field_direct_voltage(fdv), .sr_clk(sr_clk),
        .sr_load(sr_load), .sr_data(sr_data), .direct_input_a_level(dia),
        .direct_input_b_level(dib), .channel_on(chon), .program_restart(program_restart),
        .lines_released(lines_released), .input_image_byte(img));
    pdio_prog_model i_prog (.clk(clk), .feed(feed), .instr_done(instr_done));
    initial forever #10 clk = !clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_out;
        @(posedge clk) ena <= 8'h3f;
        lvl <= 8'h5a;
        wt(4);
        chk(chon, 8'h25);
        @(posedge clk) flt <= 8'h01;
        wt(3);
        chk(chon, 8'h24);
        @(posedge clk) flt <= 8'h00;
        wt(3);
        chk(chon, 8'h25);
    endtask
    task automatic t_in;
        logic [7:0] e;
        e = 8'h39;
        @(posedge clk) fv <= 8'hc6;
        fdv <= 2'h1;
        wt(10);
        chk(img, e);
        chk({6'h0, dib, dia}, 8'h02);
        @(posedge clk) sr_load <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            wt(8);
            chk({7'h0, sr_data}, {7'h0, e[i]});
            @(posedge clk) sr_clk <= 1'b1;
            wt(8);
            @(posedge clk) sr_clk <= 1'b0;
        end
        @(posedge clk) sr_load <= 1'b0;
    endtask
    task automatic t_wdog;
        @(posedge clk) feed <= 1'b0;
        for (int i = 0; i < 300 && program_restart !== 1'b1; i++) @(negedge clk);
        chk({7'h0, program_restart}, 8'h01);
        @(posedge clk) feed <= 1'b1;
        wt(2);
        chk({7'h0, lines_released}, 8'h01);
        chk(chon, 8'h00);
        wt(30);
        chk(chon, 8'h25);
    endtask
    always @(posedge clk) if (++cyc == 3000) begin
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        chk({7'h0, lines_released}, 8'h01);
        chk(chon, 8'h00);
        wt(30);
        chk({7'h0, lines_released}, 8'h00);
        t_out();
        t_in();
        t_wdog();
        conclude();
    end
endmodule
`default_nettype wire
